// ### sea_pkg.sv
// Package with constants and types for the system control event aggregator.
package sea_pkg;

   // Register offsets on the plain register port (word index).
   localparam logic [7:0] SEA_OFF_FIX_STS_A = 8'h00;
   localparam logic [7:0] SEA_OFF_FIX_EN_A  = 8'h01;
   localparam logic [7:0] SEA_OFF_FIX_STS_B = 8'h02;
   localparam logic [7:0] SEA_OFF_FIX_EN_B  = 8'h03;
   localparam logic [7:0] SEA_OFF_CTRL      = 8'h04;
   localparam logic [7:0] SEA_OFF_STATE     = 8'h05;
   localparam logic [7:0] SEA_OFF_GP0_BASE  = 8'h10;
   localparam logic [7:0] SEA_OFF_GP1_BASE  = 8'h20;
   // Within a GP block: status words, enable words, edge-type words.
   localparam logic [3:0] SEA_GP_STS_OFF    = 4'h0;
   localparam logic [3:0] SEA_GP_EN_OFF     = 4'h4;
   localparam logic [3:0] SEA_GP_EDGE_OFF   = 4'h8;

   // Fixed status/enable bit positions.
   localparam int SEA_BIT_TIMER   = 0;
   localparam int SEA_BIT_BUSMSTR = 4;
   localparam int SEA_BIT_LOCKREL = 5;
   localparam int SEA_BIT_PWRBTN  = 8;
   localparam int SEA_BIT_SLPBTN  = 9;
   localparam int SEA_BIT_ALARM   = 10;
   localparam int SEA_BIT_WAKE    = 15;
   localparam int SEA_FIX_W       = 16;

   // Bits that may be enabled; the others never reach the interrupt.
   localparam logic [15:0] SEA_FIX_EN_MASK = 16'h0721;
   localparam logic [15:0] SEA_FIX_RST     = 16'h0000;
   localparam logic [31:0] SEA_WORD_RST    = 32'h0000_0000;

   // Control bits.
   localparam int SEA_CTRL_SLEEP_REQ = 0;

   typedef enum logic [1:0] {
      SEA_WORKING  = 2'b00,
      SEA_SLEEPING = 2'b01,
      SEA_WAKING   = 2'b11
   } sea_state_type;

   typedef struct packed {
      logic timer;
      logic pwr_btn;
      logic slp_btn;
      logic alarm;
      logic bus_master;
      logic lock_release;
   } sea_fix_evt_type;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } sea_bus_type;

endpackage

// ### sea_gp_block.sv
// One general-purpose event block: latching status, enable, edge or level.
`timescale 1ns/1ps
module sea_gp_block
   import sea_pkg::*;
#(
   parameter int WIDTH = 128
)(
   input  wire logic             core_clk_in,
   input  wire logic             nrst_in,
   input  wire logic [WIDTH-1:0] event_in,
   input  wire logic [WIDTH-1:0] sts_clr_in,
   input  wire logic [WIDTH-1:0] en_wr_in,
   input  wire logic [WIDTH-1:0] en_val_in,
   input  wire logic [WIDTH-1:0] edge_wr_in,
   input  wire logic [WIDTH-1:0] edge_val_in,
   output logic      [WIDTH-1:0] status_out,
   output logic      [WIDTH-1:0] enable_out,
   output logic      [WIDTH-1:0] edge_out,
   output logic                  pending_out
);

   logic [WIDTH-1:0] prev_reg;
   logic [WIDTH-1:0] hit;

   // Edge-type inputs fire on a rising edge, level-type while high.
   assign hit = (event_in & ~(edge_out & prev_reg));

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= event_in;
      end
   end

   // Set wins over a same-cycle clear so no event is lost.
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         status_out <= '0;
      end else begin
         status_out <= (status_out & ~sts_clr_in) | hit;
      end
   end

   // Each status bit has its own enable at the same position.
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         enable_out <= '0;
         edge_out   <= '0;
      end else begin
         enable_out <= (enable_out & ~en_wr_in) |
                       (en_val_in & en_wr_in);
         edge_out   <= (edge_out & ~edge_wr_in) | (edge_val_in & edge_wr_in);
      end
   end

   assign pending_out = |(status_out & enable_out);

endmodule

// ### sea_top.sv
// Top of the system control event aggregator with its register port.
`timescale 1ns/1ps
module sea_top
   import sea_pkg::*;
#(
   parameter int  GP0_WIDTH      = 128,
   parameter int  GP1_WIDTH      = 128,
   parameter bit  HAS_ALARM_BIT  = 1'b1,
   parameter bit  HAS_BUTTON_BITS = 1'b1
)(
   input  wire logic                 core_clk_in,
   input  wire logic                 nrst_in,
   input  wire logic [7:0]           reg_addr_in,
   input  wire logic [31:0]          reg_wdata_in,
   input  wire logic                 reg_wr_in,
   input  wire logic                 reg_rd_in,
   output logic      [31:0]          reg_rdata_out,
   input  wire logic                 timer_evt_in,
   input  wire logic                 pwr_btn_in,
   input  wire logic                 slp_btn_in,
   input  wire logic                 alarm_evt_in,
   input  wire logic                 bus_master_evt_in,
   input  wire logic                 lock_release_evt_in,
   input  wire logic                 sleep_done_in,
   input  wire logic [GP0_WIDTH-1:0] gp0_event_in,
   input  wire logic [GP1_WIDTH-1:0] gp1_event_in,
   output logic                      system_control_irq_out,
   output logic                      sleeping_out
);

   localparam int GP0_WORDS = (GP0_WIDTH + 31) / 32;
   localparam int GP1_WORDS = (GP1_WIDTH + 31) / 32;
   localparam logic [7:0] GP0_STS  = SEA_OFF_GP0_BASE + 8'(SEA_GP_STS_OFF);
   localparam logic [7:0] GP0_EN   = SEA_OFF_GP0_BASE + 8'(SEA_GP_EN_OFF);
   localparam logic [7:0] GP0_EDGE = SEA_OFF_GP0_BASE + 8'(SEA_GP_EDGE_OFF);
   localparam logic [7:0] GP1_STS  = SEA_OFF_GP1_BASE + 8'(SEA_GP_STS_OFF);
   localparam logic [7:0] GP1_EN   = SEA_OFF_GP1_BASE + 8'(SEA_GP_EN_OFF);
   localparam logic [7:0] GP1_EDGE = SEA_OFF_GP1_BASE + 8'(SEA_GP_EDGE_OFF);
   // Block sizes are checked at elaboration.
   if (GP0_WIDTH > 128 || GP1_WIDTH > 128 ||
       GP0_WIDTH + GP1_WIDTH > 256) begin : g_size_check
      $error("general-purpose blocks exceed their size limit");
   end

   sea_bus_type     bus;
   sea_fix_evt_type fix_sync;
   logic [5:0]      fs1_reg;
   logic [5:0]      fs2_reg;
   logic [5:0]      fs3_reg;
   logic [5:0]      fix_lvl_reg;
   logic [5:0]      fix_prev_reg;
   logic [2:0]      wk_sync_reg;
   logic            wk_lvl_reg;
   logic            wk_prev_reg;
   logic [SEA_FIX_W-1:0] fix_sts_a_reg;
   logic [SEA_FIX_W-1:0] fix_en_a_reg;
   logic [SEA_FIX_W-1:0] fix_sts_b_reg;
   logic [SEA_FIX_W-1:0] fix_en_b_reg;
   logic [SEA_FIX_W-1:0] fix_set;
   sea_state_type        state_reg;
   logic            fix_pend;
   logic            gp0_pend;
   logic            gp1_pend;
   logic [GP0_WIDTH-1:0] gp0_sts;
   logic [GP0_WIDTH-1:0] gp0_en;
   logic [GP0_WIDTH-1:0] gp0_edge;
   logic [GP1_WIDTH-1:0] gp1_sts;
   logic [GP1_WIDTH-1:0] gp1_en;
   logic [GP1_WIDTH-1:0] gp1_edge;
   logic [GP0_WIDTH-1:0] gp0_clr;
   logic [GP0_WIDTH-1:0] gp0_enw;
   logic [GP0_WIDTH-1:0] gp0_edw;
   logic [GP0_WIDTH-1:0] gp0_val;
   logic [GP1_WIDTH-1:0] gp1_clr;
   logic [GP1_WIDTH-1:0] gp1_enw;
   logic [GP1_WIDTH-1:0] gp1_edw;
   logic [GP1_WIDTH-1:0] gp1_val;

   assign bus.wr    = reg_wr_in;
   assign bus.rd    = reg_rd_in;
   assign bus.addr  = reg_addr_in;
   assign bus.wdata = reg_wdata_in;

   // True when the address selects word idx of one GP block register.
   function automatic logic word_hit(input logic [7:0] addr,
                                     input logic [7:0] base,
                                     input int         idx);
      word_hit = (addr == base + 8'(idx));
   endfunction

   // Pin events pass three flops; a change counts when stages two and three
   // agree, which also rejects single-cycle glitches.
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         fs1_reg     <= '0;
         fs2_reg     <= '0;
         fs3_reg     <= '0;
         fix_lvl_reg <= '0;
         fix_prev_reg <= '0;
         wk_sync_reg <= '0;
         wk_lvl_reg  <= 1'b0;
         wk_prev_reg <= 1'b0;
      end else begin
         fs1_reg <= {timer_evt_in, pwr_btn_in, slp_btn_in, alarm_evt_in,
                     bus_master_evt_in, lock_release_evt_in};
         fs2_reg <= fs1_reg;
         fs3_reg <= fs2_reg;
         fix_lvl_reg <= (fs2_reg & fs3_reg) |
                        (fix_lvl_reg & (fs2_reg | fs3_reg));
         fix_prev_reg <= fix_lvl_reg;
         wk_sync_reg <= {wk_sync_reg[1:0], sleep_done_in};
         if (wk_sync_reg[1] == wk_sync_reg[2]) begin
            wk_lvl_reg <= wk_sync_reg[2];
         end
         wk_prev_reg <= wk_lvl_reg;
      end
   end

   // Rising edges of the filtered pins become one-cycle event pulses.
   assign fix_sync = sea_fix_evt_type'(fix_lvl_reg & ~fix_prev_reg);
   always_comb begin
      fix_set = '0;
      fix_set[SEA_BIT_TIMER]   = fix_sync.timer;
      fix_set[SEA_BIT_BUSMSTR] = fix_sync.bus_master;
      fix_set[SEA_BIT_LOCKREL] = fix_sync.lock_release;
      fix_set[SEA_BIT_PWRBTN]  = fix_sync.pwr_btn & HAS_BUTTON_BITS;
      fix_set[SEA_BIT_SLPBTN]  = fix_sync.slp_btn & HAS_BUTTON_BITS;
      fix_set[SEA_BIT_ALARM]   = fix_sync.alarm & HAS_ALARM_BIT;
      fix_set[SEA_BIT_WAKE]    = wk_lvl_reg & ~wk_prev_reg &
                                 (state_reg == SEA_SLEEPING);
   end

   // Fixed status A latches events, B takes none; write one to clear; a new event beats the clear.
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         fix_sts_a_reg <= SEA_FIX_RST;
         fix_sts_b_reg <= SEA_FIX_RST;
      end else begin
         fix_sts_a_reg <= (fix_sts_a_reg &
            ~((bus.wr && bus.addr == SEA_OFF_FIX_STS_A) ?
              bus.wdata[SEA_FIX_W-1:0] : SEA_FIX_RST)) | fix_set;
         fix_sts_b_reg <= (fix_sts_b_reg &
            ~((bus.wr && bus.addr == SEA_OFF_FIX_STS_B) ?
              bus.wdata[SEA_FIX_W-1:0] : SEA_FIX_RST));
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         fix_en_a_reg <= SEA_FIX_RST;
         fix_en_b_reg <= SEA_FIX_RST;
      end else if (bus.wr && bus.addr == SEA_OFF_FIX_EN_A) begin
         fix_en_a_reg <= bus.wdata[SEA_FIX_W-1:0] & SEA_FIX_EN_MASK;
      end else if (bus.wr && bus.addr == SEA_OFF_FIX_EN_B) begin
         fix_en_b_reg <= bus.wdata[SEA_FIX_W-1:0] & SEA_FIX_EN_MASK;
      end
   end
   // Wake status has no enable: it never raises the interrupt itself.
   assign fix_pend = |(fix_sts_a_reg & fix_en_a_reg) |
                     |(fix_sts_b_reg & fix_en_b_reg);

   // Write strobes and data toward the two GP blocks.
   always_comb begin
      gp0_clr = '0;
      gp0_enw = '0;
      gp0_edw = '0;
      gp0_val = '0;
      gp1_clr = '0;
      gp1_enw = '0;
      gp1_edw = '0;
      gp1_val = '0;
      for (int w = 0; w < GP0_WORDS; w++) begin
         for (int b = 0; b < 32; b++) begin
            if (w * 32 + b < GP0_WIDTH) begin
               gp0_val[w*32+b] = bus.wdata[b];
               gp0_clr[w*32+b] = bus.wr & bus.wdata[b] &
                                 word_hit(bus.addr, GP0_STS, w);
               gp0_enw[w*32+b] = bus.wr & word_hit(bus.addr, GP0_EN, w);
               gp0_edw[w*32+b] = bus.wr & word_hit(bus.addr, GP0_EDGE, w);
            end
         end
      end
      for (int w = 0; w < GP1_WORDS; w++) begin
         for (int b = 0; b < 32; b++) begin
            if (w * 32 + b < GP1_WIDTH) begin
               gp1_val[w*32+b] = bus.wdata[b];
               gp1_clr[w*32+b] = bus.wr & bus.wdata[b] &
                                 word_hit(bus.addr, GP1_STS, w);
               gp1_enw[w*32+b] = bus.wr & word_hit(bus.addr, GP1_EN, w);
               gp1_edw[w*32+b] = bus.wr & word_hit(bus.addr, GP1_EDGE, w);
            end
         end
      end
   end

   // GP event inputs come from logic on the same clock; no synchroniser.
   sea_gp_block #(.WIDTH(GP0_WIDTH)) u_gp_event_block_zero (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .event_in    (gp0_event_in),
      .sts_clr_in  (gp0_clr),
      .en_wr_in    (gp0_enw),
      .en_val_in   (gp0_val),
      .edge_wr_in  (gp0_edw),
      .edge_val_in (gp0_val),
      .status_out  (gp0_sts),
      .enable_out  (gp0_en),
      .edge_out    (gp0_edge),
      .pending_out (gp0_pend)
   );

   sea_gp_block #(.WIDTH(GP1_WIDTH)) u_gp_event_block_one (
      .core_clk_in (core_clk_in),
      .nrst_in     (nrst_in),
      .event_in    (gp1_event_in),
      .sts_clr_in  (gp1_clr),
      .en_wr_in    (gp1_enw),
      .en_val_in   (gp1_val),
      .edge_wr_in  (gp1_edw),
      .edge_val_in (gp1_val),
      .status_out  (gp1_sts),
      .enable_out  (gp1_en),
      .edge_out    (gp1_edge),
      .pending_out (gp1_pend)
   );

   // The level output follows pending bits, so it drops once software has
   // cleared or masked the last one and can be wire-ORed with others.
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         system_control_irq_out <= 1'b0;
      end else begin
         system_control_irq_out <= fix_pend | gp0_pend | gp1_pend;
      end
   end

   // Sleep is entered by software; an enabled GP event returns to working.
   // Buttons only post status and never move the state by themselves.
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         state_reg <= SEA_WORKING;
      end else begin
         case (state_reg)
            SEA_WORKING: begin
               if (bus.wr && bus.addr == SEA_OFF_CTRL &&
                   bus.wdata[SEA_CTRL_SLEEP_REQ]) begin
                  state_reg <= SEA_SLEEPING;
               end
            end
            SEA_SLEEPING: begin
               if (gp0_pend || gp1_pend) begin
                  state_reg <= SEA_WAKING;
               end
            end
            SEA_WAKING: begin
               state_reg <= SEA_WORKING;
            end
            default: begin
               state_reg <= SEA_WORKING;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         sleeping_out <= 1'b0;
      end else begin
         sleeping_out <= (state_reg == SEA_SLEEPING);
      end
   end

   // Read data appear the cycle after the strobe; unmapped reads give zero.
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= SEA_WORD_RST;
      end else begin
         reg_rdata_out <= SEA_WORD_RST;
         if (bus.rd) begin
            if (bus.addr == SEA_OFF_FIX_STS_A) begin
               reg_rdata_out <= {16'h0000, fix_sts_a_reg};
            end else if (bus.addr == SEA_OFF_FIX_EN_A) begin
               reg_rdata_out <= {16'h0000, fix_en_a_reg};
            end else if (bus.addr == SEA_OFF_FIX_STS_B) begin
               reg_rdata_out <= {16'h0000, fix_sts_b_reg};
            end else if (bus.addr == SEA_OFF_FIX_EN_B) begin
               reg_rdata_out <= {16'h0000, fix_en_b_reg};
            end else if (bus.addr == SEA_OFF_STATE) begin
               reg_rdata_out <= {30'h0000_0000, state_reg};
            end else begin
               for (int w = 0; w < GP0_WORDS; w++) begin
                  for (int b = 0; b < 32; b++) begin
                     if (w * 32 + b < GP0_WIDTH) begin
                        if (word_hit(bus.addr, GP0_STS, w))
                           reg_rdata_out[b] <= gp0_sts[w*32+b];
                        if (word_hit(bus.addr, GP0_EN, w))
                           reg_rdata_out[b] <= gp0_en[w*32+b];
                        if (word_hit(bus.addr, GP0_EDGE, w))
                           reg_rdata_out[b] <= gp0_edge[w*32+b];
                     end
                  end
               end
               for (int w = 0; w < GP1_WORDS; w++) begin
                  for (int b = 0; b < 32; b++) begin
                     if (w * 32 + b < GP1_WIDTH) begin
                        if (word_hit(bus.addr, GP1_STS, w))
                           reg_rdata_out[b] <= gp1_sts[w*32+b];
                        if (word_hit(bus.addr, GP1_EN, w))
                           reg_rdata_out[b] <= gp1_en[w*32+b];
                        if (word_hit(bus.addr, GP1_EDGE, w))
                           reg_rdata_out[b] <= gp1_edge[w*32+b];
                     end
                  end
               end
            end
         end
      end
   end

endmodule

// ### sea_monitor.sv
// Checker of register port and interrupt timing at the aggregator top.
`timescale 1ns/1ps
module sea_monitor
   import sea_pkg::*;
#(
   parameter int GP0_WIDTH = 128,
   parameter int GP1_WIDTH = 128
)(
   input  wire logic                 core_clk_in,
   input  wire logic                 nrst_in,
   input  wire logic [7:0]           reg_addr_in,
   input  wire logic [31:0]          reg_wdata_in,
   input  wire logic                 reg_wr_in,
   input  wire logic                 reg_rd_in,
   input  wire logic [31:0]          reg_rdata_out,
   input  wire logic                 timer_evt_in,
   input  wire logic                 pwr_btn_in,
   input  wire logic                 slp_btn_in,
   input  wire logic                 alarm_evt_in,
   input  wire logic                 bus_master_evt_in,
   input  wire logic                 lock_release_evt_in,
   input  wire logic                 sleep_done_in,
   input  wire logic [GP0_WIDTH-1:0] gp0_event_in,
   input  wire logic [GP1_WIDTH-1:0] gp1_event_in,
   input  wire logic                 system_control_irq_out,
   input  wire logic                 sleeping_out
);
   logic       sleep_wr;
   logic       sleep_wr_reg;
   logic       src_any;
   logic [3:0] quiet_reg;

   assign sleep_wr = reg_wr_in && reg_addr_in == SEA_OFF_CTRL
                     && reg_wdata_in[SEA_CTRL_SLEEP_REQ];
   assign src_any = reg_wr_in || timer_evt_in || pwr_btn_in || slp_btn_in
                    || alarm_evt_in || bus_master_evt_in
                    || lock_release_evt_in || (|gp0_event_in)
                    || (|gp1_event_in);

   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         sleep_wr_reg <= 1'b0;
      end else begin
         sleep_wr_reg <= sleep_wr;
      end
   end

   // Cycles since any cause; an interrupt with no recent cause is spurious.
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in || src_any) begin
         quiet_reg <= 4'h0;
      end else if (quiet_reg != 4'hF) begin
         quiet_reg <= quiet_reg + 4'h1;
      end
   end

   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!nrst_in);

   idle_rdata_a:
      assert property (!reg_rd_in |=> reg_rdata_out == 32'h0000_0000)
      else $error("read data not zero outside a read");
   unmapped_read_a:
      assert property (reg_rd_in && reg_addr_in inside {[8'h06:8'h0F],
         [8'h1C:8'h1F], [8'h2C:8'hFF]} |=> reg_rdata_out == 32'h0000_0000)
      else $error("unmapped read returned data");
   enable_mask_a:
      assert property (reg_rd_in && reg_addr_in == SEA_OFF_FIX_EN_A |=>
         (reg_rdata_out & ~{16'h0000, SEA_FIX_EN_MASK}) == 32'h0000_0000)
      else $error("fixed enable shows an unimplemented bit");
   fixed_width_a:
      assert property (reg_rd_in && reg_addr_in <= SEA_OFF_FIX_EN_B |=>
         reg_rdata_out[31:16] == 16'h0000)
      else $error("fixed register wider than sixteen bits");
   irq_cause_a:
      assert property ($rose(system_control_irq_out) |-> quiet_reg <= 4'h7)
      else $error("interrupt rose with no recent cause");
   irq_level_a:
      assert property (system_control_irq_out && !reg_wr_in
         && !$past(reg_wr_in) |=> system_control_irq_out)
      else $error("interrupt dropped without a software write");
   sleep_entry_a:
      assert property ($rose(sleeping_out) |-> $past(sleep_wr)
         || $past(sleep_wr_reg))
      else $error("sleep entered without a sleep request");
   work_stay_a:
      assert property (!sleeping_out && !sleep_wr && !sleep_wr_reg
         |=> !sleeping_out)
      else $error("working state left on its own");
   wake_irq_a:
      assert property ($fell(sleeping_out) |-> ##[0:2]
         system_control_irq_out)
      else $error("wake from sleep without interrupt");
endmodule

bind sea_top sea_monitor #(
   .GP0_WIDTH(GP0_WIDTH),
   .GP1_WIDTH(GP1_WIDTH)
) sea_monitor_i (
   .core_clk_in(core_clk_in),
   .nrst_in(nrst_in),
   .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in),
   .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out),
   .timer_evt_in(timer_evt_in),
   .pwr_btn_in(pwr_btn_in),
   .slp_btn_in(slp_btn_in),
   .alarm_evt_in(alarm_evt_in),
   .bus_master_evt_in(bus_master_evt_in),
   .lock_release_evt_in(lock_release_evt_in),
   .sleep_done_in(sleep_done_in),
   .gp0_event_in(gp0_event_in),
   .gp1_event_in(gp1_event_in),
   .system_control_irq_out(system_control_irq_out),
   .sleeping_out(sleeping_out)
);

// ### sea_os_model.sv
// Behavioural power manager that counts interrupt requests it receives.
`timescale 1ns/1ps
module sea_os_model (
   input  wire logic core_clk_in,
   input  wire logic nrst_in,
   input  wire logic irq_in,
   output int        rise_count_out
);
   logic irq_reg;

   // A shared level line is counted once per rise, not once per cycle.
   always_ff @(posedge core_clk_in) begin
      if (!nrst_in) begin
         irq_reg <= 1'b0;
         rise_count_out <= 0;
      end else begin
         irq_reg <= irq_in;
         if (irq_in && !irq_reg) begin
            rise_count_out <= rise_count_out + 1;
         end
      end
   end
endmodule

// ### sea_top_bench.sv
// Testbench driving the aggregator through its register port and pins.
`timescale 1ns/1ps
module sea_top_bench;
   import sea_pkg::*;
   logic         clk;
   logic         nrst;
   logic [7:0]   addr;
   logic [31:0]  wdata;
   logic         wr;
   logic         rd;
   logic [31:0]  rdata;
   logic [5:0]   pin;
   logic         done_pin;
   logic [127:0] gp0;
   logic [127:0] gp1;
   logic         irq;
   logic         sleeping;
   int           rises;
   int           fails;
   int           checks_done;
   int           exp_rises;
   int           fbit [6] = '{0, 4, 5, 8, 9, 10};
   logic [7:0]   regs [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h10,
                               8'h14, 8'h18, 8'h23, 8'h27, 8'h2B, 8'h06,
                               8'h1F, 8'h3F};

   sea_top #(.GP0_WIDTH(128), .GP1_WIDTH(128)) sea_top_i (
      .core_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .timer_evt_in(pin[0]),
      .bus_master_evt_in(pin[1]), .lock_release_evt_in(pin[2]),
      .pwr_btn_in(pin[3]), .slp_btn_in(pin[4]), .alarm_evt_in(pin[5]),
      .sleep_done_in(done_pin), .gp0_event_in(gp0), .gp1_event_in(gp1),
      .system_control_irq_out(irq), .sleeping_out(sleeping));

   sea_os_model sea_os_model_i (.core_clk_in(clk), .nrst_in(nrst),
      .irq_in(irq), .rise_count_out(rises));

   always #20 clk = ~clk;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("checks_done=%0d fails=%0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe; sampled mid-cycle.
   task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, exp);
   endtask

   task automatic irq_is(input logic e);
      @(negedge clk);
      check(32'(irq), 32'(e));
   endtask

   function automatic logic [7:0] gpa(int b, logic [3:0] off, int w);
      return (b != 0 ? SEA_OFF_GP1_BASE : SEA_OFF_GP0_BASE)
             + {4'h0, off} + 8'(w);
   endfunction

   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      tally_and_finish;
   end

   initial begin
      clk = 1'b0; nrst = 1'b0; addr = 8'h00; wdata = 32'h0000_0000;
      wr = 1'b0; rd = 1'b0; pin = 6'h00; done_pin = 1'b0;
      gp0 = '0; gp1 = '0; fails = 0; checks_done = 0; exp_rises = 0;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      foreach (regs[i]) rreg(regs[i], 32'h0000_0000);
      wreg(SEA_OFF_FIX_EN_A, 32'hFFFF_FFFF);
      rreg(SEA_OFF_FIX_EN_A, {16'h0000, SEA_FIX_EN_MASK});
      wreg(SEA_OFF_FIX_EN_A, 32'h0000_0000);
      wreg(SEA_OFF_FIX_EN_B, 32'hFFFF_FFFF);
      rreg(SEA_OFF_FIX_EN_B, {16'h0000, SEA_FIX_EN_MASK});
      wreg(SEA_OFF_FIX_EN_B, 32'h0000_0000);
      for (int w = 0; w < 8; w++)
         wreg(gpa(w / 4, SEA_GP_EN_OFF, w % 4), 32'hC3A5_5A00 | 32'(w));
      for (int w = 0; w < 8; w++)
         rreg(gpa(w / 4, SEA_GP_EN_OFF, w % 4), 32'hC3A5_5A00 | 32'(w));
      for (int w = 0; w < 8; w++)
         wreg(gpa(w / 4, SEA_GP_EN_OFF, w % 4), 32'h0000_0000);
      // Each source first latches while masked, then the enable releases it, except bus master (bit 4), which stays masked.
      foreach (fbit[i]) begin
         logic [31:0] b;
         logic        on;
         b = 32'h0000_0001 << fbit[i];
         on = |(b[15:0] & SEA_FIX_EN_MASK);
         @(posedge clk);
         pin[i] <= 1'b1;
         cyc(5);
         pin[i] <= 1'b0;
         cyc(6);
         rreg(SEA_OFF_FIX_STS_A, b);
         irq_is(1'b0);
         wreg(SEA_OFF_FIX_EN_A, b);
         cyc(2);
         irq_is(on);
         exp_rises += int'(on);
         check(32'(sleeping), 32'h0000_0000);
         wreg(SEA_OFF_FIX_STS_A, b);
         cyc(2);
         irq_is(1'b0);
         rreg(SEA_OFF_FIX_STS_A, 32'h0000_0000);
         wreg(SEA_OFF_FIX_EN_A, 32'h0000_0000);
      end
      wreg(gpa(0, SEA_GP_EN_OFF, 1), 32'h0000_0020);
      @(posedge clk);
      gp0[37] <= 1'b1;
      cyc(3);
      irq_is(1'b1);
      exp_rises++;
      wreg(gpa(0, SEA_GP_STS_OFF, 1), 32'h0000_0020);
      rreg(gpa(0, SEA_GP_STS_OFF, 1), 32'h0000_0020);
      irq_is(1'b1);
      @(posedge clk);
      gp0[37] <= 1'b0;
      wreg(gpa(0, SEA_GP_STS_OFF, 1), 32'h0000_0020);
      cyc(2);
      irq_is(1'b0);
      rreg(gpa(0, SEA_GP_STS_OFF, 1), 32'h0000_0000);
      wreg(gpa(0, SEA_GP_EN_OFF, 1), 32'h0000_0000);
      wreg(gpa(1, SEA_GP_EDGE_OFF, 3), 32'h8000_0000);
      wreg(gpa(1, SEA_GP_EN_OFF, 3), 32'h8000_0000);
      @(posedge clk);
      gp1[127] <= 1'b1;
      cyc(3);
      irq_is(1'b1);
      exp_rises++;
      wreg(gpa(1, SEA_GP_STS_OFF, 3), 32'h8000_0000);
      cyc(2);
      irq_is(1'b0);
      rreg(gpa(1, SEA_GP_STS_OFF, 3), 32'h0000_0000);
      rreg(gpa(1, SEA_GP_EDGE_OFF, 3), 32'h8000_0000);
      @(posedge clk);
      gp1[127] <= 1'b0;
      gp1[0] <= 1'b1;
      @(posedge clk);
      gp1[0] <= 1'b0;
      cyc(2);
      irq_is(1'b0);
      rreg(gpa(1, SEA_GP_STS_OFF, 0), 32'h0000_0001);
      wreg(gpa(1, SEA_GP_STS_OFF, 0), 32'h0000_0001);
      wreg(SEA_OFF_CTRL, 32'h0000_0001);
      cyc(2);
      check(32'(sleeping), 32'h0000_0001);
      rreg(SEA_OFF_STATE, 32'h0000_0001);
      @(posedge clk);
      done_pin <= 1'b1;
      cyc(5);
      done_pin <= 1'b0;
      cyc(6);
      rreg(SEA_OFF_FIX_STS_A, 32'h0000_8000);
      irq_is(1'b0);
      wreg(gpa(0, SEA_GP_EN_OFF, 0), 32'h0000_0008);
      @(posedge clk);
      gp0[3] <= 1'b1;
      @(posedge clk);
      gp0[3] <= 1'b0;
      cyc(4);
      irq_is(1'b1);
      exp_rises++;
      check(32'(sleeping), 32'h0000_0000);
      rreg(SEA_OFF_STATE, 32'h0000_0000);
      wreg(gpa(0, SEA_GP_STS_OFF, 0), 32'h0000_0008);
      wreg(SEA_OFF_FIX_STS_A, 32'h0000_8000);
      cyc(2);
      irq_is(1'b0);
      check(32'(rises), 32'(exp_rises));
      tally_and_finish;
   end
endmodule
